/* common/flash_seq_pkg.sv */
/*
  Shared constants and types of the whole-array erase, sleep and power-up sequencer.
  Assumes a 25 MHz system clock and a serial link sampled on rising serial clock edges.
*/
package flash_seq_pkg;

  // system clock
  localparam int unsigned CLK_PERIOD_NS = 40;

  // serial frame layout
  localparam int unsigned CMD_BITS    = 8;
  localparam int unsigned CNT_BITS    = 4;
  localparam logic [3:0]  FULL_FRAME  = 4'h8;
  localparam logic [3:0]  SAT_FRAME   = 4'h9;

  // instruction codes, values chosen for this block
  localparam logic [7:0] OP_WRITE_ARM  = 8'h11;
  localparam logic [7:0] OP_CHIP_CLEAR = 8'h22;
  localparam logic [7:0] OP_SLEEP      = 8'h33;
  localparam logic [7:0] OP_WAKE       = 8'h44;

  // value every byte holds after a whole-array erase
  localparam logic [7:0] FILL_BYTE = 8'hFF;

  // delays in their own units
  localparam int unsigned CHIP_CLEAR_TIME_US     = 2000;
  localparam int unsigned WRITE_INHIBIT_DELAY_US = 1000;
  localparam int unsigned SLEEP_ENTRY_DELAY_NS   = 3000;
  localparam int unsigned WAKE_DELAY_NS          = 30000;

  // delays in clock cycles, least times rounded up
  localparam int unsigned CHIP_CLEAR_CYCLES =
    (CHIP_CLEAR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_INHIBIT_CYCLES =
    (WRITE_INHIBIT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_ENTRY_CYCLES =
    (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYCLES =
    (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_STANDBY     = 3'h0,
    ST_ERASING     = 3'h1,
    ST_SLEEP_ENTRY = 3'h2,
    ST_SLEEP       = 3'h3,
    ST_WAKING      = 3'h4
  } seq_state_t;

  // what the link end holds about the last frame
  typedef struct packed {
    logic                empty;
    logic [CNT_BITS-1:0] count;
    logic [CMD_BITS-1:0] opcode;
  } link_word_t;

endpackage

/* hw/link_shift.sv */
/*
  Serial link end: counts the bits of a frame and keeps its first eight as the code.
  Runs on the serial clock, which only toggles while chip select is low; the result stays
  frozen after chip select rises until the first clock of the next frame.
*/
`timescale 1ns/1ps
module link_shift (
  input  wire logic                      spi_clk_i,
  input  wire logic                      cs_n_i,
  input  wire logic                      mosi_i,
  output flash_seq_pkg::link_word_t      link_word_o
);

  flash_seq_pkg::link_word_t state;
  flash_seq_pkg::link_word_t next_state;

  always_comb begin
    next_state = state;
    if (state.empty) begin
      next_state.empty  = 1'b0;
      next_state.count  = 4'h1;
      next_state.opcode = {7'h00, mosi_i};
    end else if (state.count != flash_seq_pkg::SAT_FRAME) begin
      next_state.count = state.count + 4'h1;
      if (state.count < flash_seq_pkg::FULL_FRAME) begin
        next_state.opcode = {state.opcode[6:0], mosi_i};
      end
    end
  end

  // deselect only marks the next clock as a frame start, the last result stays readable
  always_ff @(posedge spi_clk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      state.empty <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign link_word_o = state;

endmodule

/* hw/delay_timer.sv */
/*
  Down counter for self-timed delays: expired goes high the given number of cycles after load.
  Assumes load and count come from logic on the same clock.
*/
`timescale 1ns/1ps
module delay_timer #(
  parameter int unsigned W           = 28,
  parameter int unsigned RESET_COUNT = 0
) (
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              expired_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         expired;
  } timer_state_t;

  timer_state_t state;
  timer_state_t next_state;

  always_comb begin
    next_state = state;
    if (load_i) begin
      next_state.cnt     = count_i;
      next_state.expired = (count_i == '0);
    end else if (state.cnt != '0) begin
      next_state.cnt     = state.cnt - {{(W-1){1'b0}}, 1'b1};
      next_state.expired = (state.cnt == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state.cnt     <= W'(RESET_COUNT);
      state.expired <= (RESET_COUNT == 0);
    end else begin
      state <= next_state;
    end
  end

  assign expired_o = state.expired;

endmodule

/* hw/flash_bulk_erase_sleep_powerup.sv */
/*
  Instruction sequencer of a serial flash for whole-array erase, write arming, deep sleep
  entry and release, and power-up write inhibit.
  Assumes rst_n_i is the power-on reset, low while supply is below the inhibit threshold;
  ext_busy_i and protect_i come from logic on clock_i; the serial clock is still while
  chip select is high.
*/
`timescale 1ns/1ps
// Functional notes
// - whole-array erase leaves every byte reading all ones
// - erase accepted only when write latch was set by write arm
// - erase frame is exactly eight bits, else not executed
// - valid erase frame end starts timed cycle; busy flag high meanwhile
// - write latch cleared during the erase cycle
// - erase during any running cycle is rejected, cycle untouched
// - erase ignored while any sector or sub-sector is protected
// - deselect gives standby only when idle, never deep sleep
// - in deep sleep only the wake code is obeyed
// - sleep frame is exactly eight bits, else not executed
// - deep sleep entered only after the sleep entry delay
// - sleep ends at power loss; power-up always lands in standby
// - wake frame with extra clocks is rejected
// - standby reached after wake delay; host keeps deselected meanwhile
// - sleep and wake rejected while a cycle runs
// - below inhibit threshold the logic is held reset, no response
// - write-type codes ignored until write inhibit delay elapses
// - after power-up: standby, write latch cleared
module flash_bulk_erase_sleep_powerup #(
  parameter int unsigned CNT_W                = 28,
  parameter int unsigned CHIP_CLEAR_CYCLES    = flash_seq_pkg::CHIP_CLEAR_CYCLES,
  parameter int unsigned WRITE_INHIBIT_CYCLES = flash_seq_pkg::WRITE_INHIBIT_CYCLES
) (
  input  wire logic  clock_i,
  input  wire logic  rst_n_i,
  input  wire logic  spi_clk_i,
  input  wire logic  cs_n_i,
  input  wire logic  mosi_i,
  input  wire logic  ext_busy_i,
  input  wire logic  protect_i,
  output logic       busy_flag_o,
  output logic       write_latch_o,
  output logic       standby_o,
  output logic       sleep_mode_o,
  output logic       write_inhibit_o,
  output logic       fill_strobe_o,
  output logic [7:0] fill_data_o,
  output logic       reject_o
);

  if (CHIP_CLEAR_CYCLES < 1 || CHIP_CLEAR_CYCLES >= (1 << CNT_W) ||
      WRITE_INHIBIT_CYCLES < 1 || WRITE_INHIBIT_CYCLES >= (1 << CNT_W) ||
      flash_seq_pkg::WAKE_CYCLES >= (1 << CNT_W) || CNT_W > 31) begin : g_bad_param
    $error("delay counts do not fit the timer width");
  end

  typedef struct packed {
    logic                      cs_meta;
    logic                      cs_sync;
    logic                      cs_prev;
    logic                      empty_meta;
    logic                      empty_sync;
    logic                      got_bits;
    logic [1:0]                warm;
    logic                      link_armed;
    flash_seq_pkg::seq_state_t st;
    logic                      write_latch;
    logic                      busy_flag;
    logic                      standby;
    logic                      sleep_mode;
    logic                      write_inhibit;
    logic                      fill_strobe;
    logic                      reject;
    logic [7:0]                fill_data;
  } seq_t;

  seq_t                      state;
  seq_t                      next_state;
  flash_seq_pkg::link_word_t link_word;
  logic                      tmr_load;
  logic [CNT_W-1:0]          tmr_count;
  logic                      tmr_expired;
  logic                      inhibit_expired;

  link_shift u_link (
    .spi_clk_i   (spi_clk_i),
    .cs_n_i      (cs_n_i),
    .mosi_i      (mosi_i),
    .link_word_o (link_word)
  );

  delay_timer #(
    .W           (CNT_W),
    .RESET_COUNT (0)
  ) u_state_timer (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .load_i    (tmr_load),
    .count_i   (tmr_count),
    .expired_o (tmr_expired)
  );

  // starts counting out of power-on reset; never reloaded
  delay_timer #(
    .W           (CNT_W),
    .RESET_COUNT (WRITE_INHIBIT_CYCLES)
  ) u_inhibit_timer (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .load_i    (1'b0),
    .count_i   ({CNT_W{1'b0}}),
    .expired_o (inhibit_expired)
  );

  // empty is already set again by the deselect, so only the count is looked at
  function automatic logic is_exact_frame(input flash_seq_pkg::link_word_t w);
    return w.count == flash_seq_pkg::FULL_FRAME;
  endfunction

  function automatic logic is_own_code(input logic [7:0] op);
    return (op == flash_seq_pkg::OP_WRITE_ARM) || (op == flash_seq_pkg::OP_CHIP_CLEAR) ||
           (op == flash_seq_pkg::OP_SLEEP) || (op == flash_seq_pkg::OP_WAKE);
  endfunction

  logic frame_end;
  logic exact;
  logic own;
  logic cycle_running;
  logic cs_rise;

  always_comb begin
    next_state = state;
    tmr_load   = 1'b0;
    tmr_count  = {CNT_W{1'b0}};

    next_state.cs_meta     = cs_n_i;
    next_state.cs_sync     = state.cs_meta;
    next_state.cs_prev     = state.cs_sync;
    next_state.fill_strobe = 1'b0;
    next_state.reject      = 1'b0;
    // only the empty marker crosses by two flops; the word is quiet by the time it is read
    next_state.empty_meta  = link_word.empty;
    next_state.empty_sync  = state.empty_meta;

    // cs sync needs two edges after reset to show the pin; frames already running are dropped
    if (state.warm != 2'h2) begin
      next_state.warm = state.warm + 2'h1;
    end
    if (state.warm == 2'h2 && state.cs_sync) begin
      next_state.link_armed = 1'b1;
    end

    // a select without serial clocks leaves the old word in place; it must not run again
    cs_rise = state.cs_sync && !state.cs_prev;
    if (state.link_armed && !state.cs_sync && !state.empty_sync) begin
      next_state.got_bits = 1'b1;
    end else if (cs_rise) begin
      next_state.got_bits = 1'b0;
    end

    // link word is frozen while chip select is high, so it is read at the synced rise
    frame_end     = cs_rise && state.got_bits;
    exact         = is_exact_frame(link_word);
    own           = is_own_code(link_word.opcode);
    cycle_running = (state.st == flash_seq_pkg::ST_ERASING) || ext_busy_i;

    next_state.write_inhibit = !inhibit_expired;

    case (state.st)
      flash_seq_pkg::ST_STANDBY: begin
        if (frame_end && own) begin
          if (!exact) begin
            next_state.reject = 1'b1;
          end else if (ext_busy_i) begin
            next_state.reject = 1'b1;
          end else begin
            case (link_word.opcode)
              flash_seq_pkg::OP_WRITE_ARM: begin
                if (state.write_inhibit) begin
                  next_state.reject = 1'b1;
                end else begin
                  next_state.write_latch = 1'b1;
                end
              end
              flash_seq_pkg::OP_CHIP_CLEAR: begin
                if (state.write_inhibit || protect_i || !state.write_latch) begin
                  next_state.reject = 1'b1;
                end else begin
                  next_state.st = flash_seq_pkg::ST_ERASING;
                  tmr_load      = 1'b1;
                  tmr_count     = CNT_W'(CHIP_CLEAR_CYCLES);
                end
              end
              flash_seq_pkg::OP_SLEEP: begin
                next_state.st = flash_seq_pkg::ST_SLEEP_ENTRY;
                tmr_load      = 1'b1;
                tmr_count     = CNT_W'(flash_seq_pkg::SLEEP_ENTRY_CYCLES);
              end
              default: begin
                // wake while awake has nothing to release
              end
            endcase
          end
        end
      end

      flash_seq_pkg::ST_ERASING: begin
        // latch drops as the cycle begins, well before it completes
        next_state.write_latch = 1'b0;
        if (frame_end && own) begin
          next_state.reject = 1'b1;
        end
        if (tmr_expired) begin
          next_state.st          = flash_seq_pkg::ST_STANDBY;
          next_state.fill_strobe = 1'b1;
        end
      end

      flash_seq_pkg::ST_SLEEP_ENTRY: begin
        if (frame_end && own) begin
          next_state.reject = 1'b1;
        end
        if (tmr_expired) begin
          next_state.st = flash_seq_pkg::ST_SLEEP;
        end
      end

      flash_seq_pkg::ST_SLEEP: begin
        if (frame_end) begin
          if (link_word.opcode == flash_seq_pkg::OP_WAKE && exact && !ext_busy_i) begin
            next_state.st = flash_seq_pkg::ST_WAKING;
            tmr_load      = 1'b1;
            tmr_count     = CNT_W'(flash_seq_pkg::WAKE_CYCLES);
          end else begin
            next_state.reject = 1'b1;
          end
        end
      end

      flash_seq_pkg::ST_WAKING: begin
        // host keeps chip select high here; any frame is dropped
        if (frame_end && own) begin
          next_state.reject = 1'b1;
        end
        if (tmr_expired) begin
          next_state.st = flash_seq_pkg::ST_STANDBY;
        end
      end

      default: begin
        next_state.st = flash_seq_pkg::ST_STANDBY;
      end
    endcase

    next_state.busy_flag  = (next_state.st == flash_seq_pkg::ST_ERASING);
    next_state.sleep_mode = (next_state.st == flash_seq_pkg::ST_SLEEP);
    // standby needs deselect and no running cycle; deselect alone never sleeps
    next_state.standby    = (next_state.st == flash_seq_pkg::ST_STANDBY) &&
                            state.cs_sync && !cycle_running;
  end

  // power-on reset: standby, latch clear, write inhibit running
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state.cs_meta       <= 1'b1;
      state.cs_sync       <= 1'b1;
      state.cs_prev       <= 1'b1;
      // link end is not on this reset; it re-arms on every deselect
      state.empty_meta    <= 1'b1;
      state.empty_sync    <= 1'b1;
      state.got_bits      <= 1'b0;
      state.warm          <= 2'h0;
      state.link_armed    <= 1'b0;
      state.st            <= flash_seq_pkg::ST_STANDBY;
      state.write_latch   <= 1'b0;
      state.busy_flag     <= 1'b0;
      state.standby       <= 1'b0;
      state.sleep_mode    <= 1'b0;
      state.write_inhibit <= 1'b1;
      state.fill_strobe   <= 1'b0;
      state.reject        <= 1'b0;
      state.fill_data     <= flash_seq_pkg::FILL_BYTE;
    end else begin
      state <= next_state;
    end
  end

  assign busy_flag_o     = state.busy_flag;
  assign write_latch_o   = state.write_latch;
  assign standby_o       = state.standby;
  assign sleep_mode_o    = state.sleep_mode;
  assign write_inhibit_o = state.write_inhibit;
  assign fill_strobe_o   = state.fill_strobe;
  assign fill_data_o     = state.fill_data;
  assign reject_o        = state.reject;

endmodule

/* verif/flash_seq_asserts.sv */
/*
  Checker of the erase, sleep and power-up sequencer outputs against their inputs.
  Assumes binding into the sequencer top, one clock domain on clock_i.
*/
`timescale 1ns/1ps
module flash_seq_asserts #(
  parameter int unsigned CHIP_CLEAR_CYCLES    = 20,
  parameter int unsigned WRITE_INHIBIT_CYCLES = 10
) (
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       cs_n_i,
  input wire logic       ext_busy_i,
  input wire logic       protect_i,
  input wire logic       busy_flag_o,
  input wire logic       write_latch_o,
  input wire logic       standby_o,
  input wire logic       sleep_mode_o,
  input wire logic       write_inhibit_o,
  input wire logic       fill_strobe_o,
  input wire logic [7:0] fill_data_o,
  input wire logic       reject_o
);
  localparam int unsigned CLR_LO = CHIP_CLEAR_CYCLES - 1;
  localparam int unsigned CLR_HI = CHIP_CLEAR_CYCLES + 1;
  localparam int unsigned INH_LO = WRITE_INHIBIT_CYCLES - 1;
  localparam int unsigned INH_HI = WRITE_INHIBIT_CYCLES + 2;
  logic [15:0] busy_cnt;
  logic [15:0] hi_cnt;
  logic [15:0] up_cnt;
  logic        waking;

  // cycle counts since erase start, chip select rise and reset release
  always_ff @(posedge clock_i) begin
    busy_cnt <= busy_flag_o ? busy_cnt + 16'h1 : 16'h0;
    hi_cnt   <= (!rst_n_i || !cs_n_i) ? 16'h0 : hi_cnt + {15'h0, hi_cnt != 16'hFFFF};
    up_cnt   <= !rst_n_i ? 16'h0 : up_cnt + 16'h1;
    waking   <= !rst_n_i ? 1'b0 : $fell(sleep_mode_o) ? 1'b1 : standby_o ? 1'b0 : waking;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  fill_value_a: assert property (fill_strobe_o |-> fill_data_o == 8'hFF)
    else $error("fill value not all ones");
  erase_gate_a: assert property ($rose(busy_flag_o) |-> $past(write_latch_o) &&
    !$past(protect_i) && !$past(ext_busy_i) && !$past(write_inhibit_o))
    else $error("erase started without its conditions");
  latch_drop_a: assert property ($rose(busy_flag_o) |=> !write_latch_o)
    else $error("write latch kept during erase");
  erase_time_a: assert property ($fell(busy_flag_o) |->
    fill_strobe_o && busy_cnt inside {[CLR_LO:CLR_HI]})
    else $error("erase length or fill wrong");
  busy_excl_a: assert property (busy_flag_o |-> !standby_o && !sleep_mode_o)
    else $error("standby or sleep during erase");
  sleep_delay_a: assert property ($rose(sleep_mode_o) |-> hi_cnt inside {[16'h004B:16'h0055]})
    else $error("sleep entry delay wrong");
  sleep_exit_a: assert property ($fell(sleep_mode_o) |-> hi_cnt inside {[16'h2:16'h6]} && !standby_o)
    else $error("sleep left without a frame");
  wake_delay_a: assert property ($rose(standby_o) && waking |-> hi_cnt inside {[16'h02EE:16'h02F8]})
    else $error("wake delay wrong");
  inhibit_end_a: assert property ($fell(write_inhibit_o) |-> up_cnt inside {[INH_LO:INH_HI]})
    else $error("write inhibit length wrong");
  inhibit_stay_a: assert property (!write_inhibit_o |=> !write_inhibit_o)
    else $error("write inhibit came back");
  arm_gate_a: assert property ($rose(write_latch_o) |->
    !$past(write_inhibit_o) && !busy_flag_o && !sleep_mode_o)
    else $error("write latch set while barred");
  reject_pulse_a: assert property (reject_o |=> !reject_o)
    else $error("refusal pulse too long");
endmodule

bind flash_bulk_erase_sleep_powerup flash_seq_asserts #(
  .CHIP_CLEAR_CYCLES(CHIP_CLEAR_CYCLES), .WRITE_INHIBIT_CYCLES(WRITE_INHIBIT_CYCLES)
) chk (.clock_i, .rst_n_i, .cs_n_i, .ext_busy_i, .protect_i, .busy_flag_o, .write_latch_o,
  .standby_o, .sleep_mode_o, .write_inhibit_o, .fill_strobe_o, .fill_data_o, .reject_o);

/* verif/spi_host.sv */
/*
  Host model: sends one frame of a given bit count, msb first, 64 ns serial clock.
  Assumes the caller spaces frames; the serial clock stands still between frames.
*/
`timescale 1ns/1ps
module spi_host (
  output logic spi_clk_o,
  output logic cs_n_o,
  output logic mosi_o
);
  // a short select before the first clock edge gives the link end a definite deselect edge
  initial begin
    spi_clk_o = 1'b0;
    cs_n_o = 1'b0;
    mosi_o = 1'b1;
    #1 cs_n_o = 1'b1;
  end

  // chip select rises right after the last bit
  task automatic send(input logic [7:0] code, input int n);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi_o = code[7 - (i % 8)];
      #32 spi_clk_o = 1'b1;
      #32 spi_clk_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    // released data line carries no stale value
    mosi_o = ~mosi_o;
    #240;
  endtask
endmodule

/* verif/flash_bulk_erase_sleep_powerup_tb.sv */
/*
  Bench of the sequencer: frames from the host model, checks of the status outputs.
  Assumes the bound checker and the host model; shortened erase and inhibit counts.
*/
`timescale 1ns/1ps
module flash_bulk_erase_sleep_powerup_tb;
  logic       clock_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       ext_busy = 1'b0;
  logic       protect = 1'b0;
  logic       spi_clk, cs_n, mosi, busy, latch, standby, sleep, inhibit, fill, reject;
  logic [7:0] fill_data;
  logic [7:0] rej_cnt = 8'h00;
  logic [7:0] fill_cnt = 8'h00;
  logic [7:0] exp_rej = 8'h00;
  int         fails = 0;
  int         n_compared = 0;
  int         cyc = 0;

  always #20 clock_i = ~clock_i;

  spi_host h (.spi_clk_o(spi_clk), .cs_n_o(cs_n), .mosi_o(mosi));
  flash_bulk_erase_sleep_powerup #(.CHIP_CLEAR_CYCLES(60), .WRITE_INHIBIT_CYCLES(40)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .spi_clk_i(spi_clk), .cs_n_i(cs_n), .mosi_i(mosi),
    .ext_busy_i(ext_busy), .protect_i(protect), .busy_flag_o(busy), .write_latch_o(latch),
    .standby_o(standby), .sleep_mode_o(sleep), .write_inhibit_o(inhibit),
    .fill_strobe_o(fill), .fill_data_o(fill_data), .reject_o(reject));

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (reject === 1'b1) rej_cnt <= rej_cnt + 8'h01;
    if (fill === 1'b1) fill_cnt <= fill_cnt + 8'h01;
    if (cyc == 6000) begin
      fails++;
      end_sim();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic tdone(input string s);
    $display("test %0s done", s);
  endtask

  // one frame, then the refusal count against its expected step
  task automatic frame(input logic [7:0] code, input int n, input logic [7:0] rej);
    @(posedge clock_i);
    #3;
    h.send(code, n);
    settle(2);
    exp_rej = exp_rej + rej;
    check(rej_cnt, exp_rej);
  endtask

  // chip select stays high through the reset
  task automatic do_reset();
    @(posedge clock_i) rst_n_i <= 1'b0;
    settle(9);
    check({busy, latch, standby, sleep, inhibit}, 8'h01);
    check(fill_data, 8'hFF);
    @(posedge clock_i) rst_n_i <= 1'b1;
    settle(2);
    check({latch, standby, sleep}, 8'h02);
  endtask

  initial begin
    do_reset();
    tdone("reset");
    frame(8'h11, 8, 8'h01);
    check({latch, inhibit}, 8'h01);
    settle(20);
    check(inhibit, 8'h00);
    tdone("inhibit");
    frame(8'h22, 8, 8'h01);
    frame(8'h11, 9, 8'h01);
    frame(8'h11, 8, 8'h00);
    check({busy, latch}, 8'h01);
    @(posedge clock_i) protect <= 1'b1;
    frame(8'h22, 8, 8'h01);
    check({busy, latch}, 8'h01);
    @(posedge clock_i) protect <= 1'b0;
    frame(8'h22, 9, 8'h01);
    @(posedge clock_i) ext_busy <= 1'b1;
    frame(8'h22, 8, 8'h01);
    check({busy, latch, standby}, 8'h02);
    @(posedge clock_i) ext_busy <= 1'b0;
    tdone("erase gating");
    frame(8'h22, 8, 8'h00);
    check({busy, latch, standby}, 8'h04);
    frame(8'h33, 8, 8'h01);
    frame(8'h11, 8, 8'h01);
    check({busy, latch, sleep}, 8'h04);
    settle(30);
    check({busy, standby}, 8'h01);
    check(fill_cnt, 8'h01);
    tdone("erase");
    frame(8'h33, 9, 8'h01);
    check({standby, sleep}, 8'h02);
    frame(8'h33, 8, 8'h00);
    check({standby, sleep}, 8'h00);
    settle(75);
    check(sleep, 8'h01);
    frame(8'h11, 8, 8'h01);
    frame(8'h44, 9, 8'h01);
    check({latch, sleep}, 8'h01);
    frame(8'h44, 8, 8'h00);
    check({standby, sleep}, 8'h00);
    settle(700);
    check(standby, 8'h00);
    settle(60);
    check(standby, 8'h01);
    tdone("sleep and wake");
    frame(8'h33, 8, 8'h00);
    settle(80);
    check(sleep, 8'h01);
    do_reset();
    tdone("power cycle");
    end_sim();
  end
endmodule
